// file: design/lscen_pkg.sv
// package for the link status and channel enable register bank
package lscen_pkg;
   // register byte addresses (printed offsets are not all multiples of four)
   localparam logic [11:0] LSCEN_IDX_STATUS  = 12'h208;
   localparam logic [11:0] LSCEN_IDX_CHAN    = 12'h209;
   localparam logic [11:0] LSCEN_IDX_FRAME_END_CHAR_SELECT   = 12'h207;
   localparam logic [11:0] LSCEN_IDX_CTRL    = 12'h20a;
   localparam int          LSCEN_AW          = 14;
   localparam logic [13:0] LSCEN_ADDR_STATUS = {LSCEN_IDX_STATUS, 2'b00};
   localparam logic [13:0] LSCEN_ADDR_CHAN   = {LSCEN_IDX_CHAN, 2'b00};
   localparam logic [13:0] LSCEN_ADDR_FRAME_END_CHAR_SELECT  = {LSCEN_IDX_FRAME_END_CHAR_SELECT, 2'b00};
   localparam logic [13:0] LSCEN_ADDR_CTRL   = {LSCEN_IDX_CTRL, 2'b00};

   // status bit positions
   localparam int LSCEN_ST_LINK    = 6;
   localparam int LSCEN_ST_SYNC    = 5;
   localparam int LSCEN_ST_REALIGN = 4;
   localparam int LSCEN_ST_PHASE   = 3;
   localparam int LSCEN_ST_SPLL    = 2;
   localparam int LSCEN_ST_CPLL    = 0;
   // channel enable bit positions
   localparam int LSCEN_CH_ONE   = 2;
   localparam int LSCEN_CH_UPPER = 1;
   localparam int LSCEN_CH_LOWER = 0;
   // control register bit positions
   localparam int LSCEN_CT_LINK_EN = 0;
   localparam int LSCEN_CT_CAL_EN  = 1;
   localparam int LSCEN_CT_ENC8B   = 2;

   // reset values
   localparam logic [7:0] LSCEN_RST_STATUS = 8'h00;
   localparam logic [7:0] LSCEN_RST_CHAN   = 8'h03;
   localparam logic [7:0] LSCEN_RST_FRAME_END_CHAR_SELECT  = 8'h00;
   localparam logic [7:0] LSCEN_RST_CTRL   = 8'h00;

   // end-of-frame comma codes and 8-bit K characters
   typedef enum logic [1:0] {
      LSCEN_COMMA_K287 = 2'h0,
      LSCEN_COMMA_K281 = 2'h1,
      LSCEN_COMMA_K285 = 2'h2,
      LSCEN_COMMA_RSVD = 2'h3
   } lscen_comma_e;
   localparam logic [7:0] LSCEN_K287 = 8'hfc;
   localparam logic [7:0] LSCEN_K281 = 8'h3c;
   localparam logic [7:0] LSCEN_K285 = 8'hbc;

   // bus response states
   typedef enum logic [1:0] {
      LSCEN_BUS_IDLE = 2'b00,
      LSCEN_BUS_ACK  = 2'b01
   } lscen_bus_e;

   // frame layout handed to the transmitter
   typedef struct packed {
      logic [3:0] lanes;
      logic [3:0] converters;
      logic       tail_pad;
      logic       swap_upper_to_lower;
      logic [3:0] chan_on;
   } lscen_frame_s;

   // live status inputs
   typedef struct packed {
      logic link_up;
      logic sync_n;
      logic spll_lock;
      logic cpll_lock;
   } lscen_live_s;
endpackage

// file: design/lscen_regs.sv
// link status and channel enable register bank with avalon-mm slave
`timescale 1ns/1ps
module lscen_regs
   import lscen_pkg::*;
#(
   parameter int FULL_LANES = 8,
   parameter int FULL_CONV  = 4
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   // avalon-mm slave
   input  wire logic [LSCEN_AW-1:0]         avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   input  wire logic [3:0]                  avs_byteenable,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   output logic      [1:0]                  avs_response,
   // asynchronous status pins
   input  wire lscen_pkg::lscen_live_s      live_in,
   // same-clock events from the transmitter
   input  wire logic                        sysref_realign,
   input  wire logic                        sysref_event,
   // transmitter control
   output logic                             serial_link_enable,
   output logic                             cal_enable,
   output logic                             enc_8b10b,
   output logic                             frame_end_comma_insert,
   output logic      [7:0]                  frame_end_comma_char,
   output lscen_pkg::lscen_frame_s          frame_cfg
);
   import lscen_pkg::*;

   localparam logic [3:0] FULL_L = 4'(FULL_LANES);
   localparam logic [3:0] FULL_M = 4'(FULL_CONV);
   localparam logic [3:0] HALF_L = 4'((FULL_LANES + 1) / 2);
   localparam logic [3:0] HALF_M = 4'(FULL_CONV / 2);

   // two-flop synchroniser for live status
   lscen_live_s live_meta, live_sync;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         live_meta <= '0;
         live_sync <= '0;
      end else begin
         live_meta <= live_in;
         live_sync <= live_meta;
      end
   end

   // register state
   lscen_bus_e bus_state, next_bus_state;
   logic [1:0] frame_end_comma_select, next_frame_end_comma_select;
   logic       one_channel_mode, next_one_channel_mode;
   logic       upper_pair_on, next_upper_pair_on;
   logic       lower_pair_on, next_lower_pair_on;
   logic       next_serial_link_enable, next_cal_enable, next_enc_8b10b;
   logic       realign_flag, next_realign_flag;
   logic       multiframe_phase_set_flag, next_multiframe_phase_set_flag;
   logic       phase_armed, next_phase_armed;
   logic       link_en_d, next_link_en_d;
   logic [31:0] next_readdata;
   logic [1:0]  next_response;
   logic        hit, wr_go, rd_go, clr4, clr3;
   logic [7:0]  status_byte;

   always_comb begin
      status_byte = 8'h00;
      status_byte[LSCEN_ST_LINK]    = live_sync.link_up;
      status_byte[LSCEN_ST_SYNC]    = live_sync.sync_n;
      status_byte[LSCEN_ST_REALIGN] = realign_flag;
      status_byte[LSCEN_ST_PHASE]   = multiframe_phase_set_flag;
      status_byte[LSCEN_ST_SPLL]    = live_sync.spll_lock;
      status_byte[LSCEN_ST_CPLL]    = live_sync.cpll_lock;
   end

   always_comb begin
      hit = (avs_address == LSCEN_ADDR_STATUS) || (avs_address == LSCEN_ADDR_CHAN) ||
            (avs_address == LSCEN_ADDR_FRAME_END_CHAR_SELECT) || (avs_address == LSCEN_ADDR_CTRL);
      wr_go = (bus_state == LSCEN_BUS_IDLE) && avs_write && avs_byteenable[0];
      rd_go = (bus_state == LSCEN_BUS_IDLE) && avs_read;
      next_bus_state = LSCEN_BUS_IDLE;
      next_readdata  = 32'h0000_0000;
      next_response  = 2'b00;
      next_frame_end_comma_select = frame_end_comma_select;
      next_one_channel_mode   = one_channel_mode;
      next_upper_pair_on      = upper_pair_on;
      next_lower_pair_on      = lower_pair_on;
      next_serial_link_enable = serial_link_enable;
      next_cal_enable         = cal_enable;
      next_enc_8b10b          = enc_8b10b;
      next_link_en_d          = serial_link_enable;
      clr4 = 1'b0;
      clr3 = 1'b0;
      case (bus_state)
         LSCEN_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_bus_state = LSCEN_BUS_ACK;
               next_response  = hit ? 2'b00 : 2'b11;
            end
            if (rd_go) begin
               case (avs_address)
                  LSCEN_ADDR_STATUS: next_readdata = {24'h000000, status_byte};
                  LSCEN_ADDR_CHAN: begin
                     next_readdata = {29'h0, one_channel_mode, upper_pair_on,
                                      lower_pair_on};
                  end
                  LSCEN_ADDR_FRAME_END_CHAR_SELECT: next_readdata = {30'h0, frame_end_comma_select};
                  LSCEN_ADDR_CTRL: begin
                     next_readdata = {29'h0, enc_8b10b, cal_enable, serial_link_enable};
                  end
                  default: next_readdata = 32'h0000_0000;
               endcase
            end
            if (wr_go) begin
               case (avs_address)
                  LSCEN_ADDR_STATUS: begin
                     clr4 = avs_writedata[LSCEN_ST_REALIGN];
                     clr3 = avs_writedata[LSCEN_ST_PHASE];
                  end
                  LSCEN_ADDR_CHAN: begin
                     next_one_channel_mode = avs_writedata[LSCEN_CH_ONE];
                     next_upper_pair_on    = avs_writedata[LSCEN_CH_UPPER];
                     next_lower_pair_on    = avs_writedata[LSCEN_CH_LOWER];
                  end
                  LSCEN_ADDR_FRAME_END_CHAR_SELECT: begin
                     next_frame_end_comma_select = avs_writedata[1:0];
                  end
                  LSCEN_ADDR_CTRL: begin
                     next_serial_link_enable = avs_writedata[LSCEN_CT_LINK_EN];
                     next_cal_enable         = avs_writedata[LSCEN_CT_CAL_EN];
                     next_enc_8b10b          = avs_writedata[LSCEN_CT_ENC8B];
                  end
                  default: ;
               endcase
            end
         end
         LSCEN_BUS_ACK: next_bus_state = LSCEN_BUS_IDLE;
         default: next_bus_state = LSCEN_BUS_IDLE;
      endcase
      // sticky flags: set wins over clear
      next_realign_flag = sysref_realign | (realign_flag & ~clr4);
      // first sysref after the link is enabled establishes the phase
      next_phase_armed = phase_armed;
      if (serial_link_enable && !link_en_d) begin
         next_phase_armed = 1'b1;
      end else if (!serial_link_enable) begin
         next_phase_armed = 1'b0;
      end
      next_multiframe_phase_set_flag = multiframe_phase_set_flag & ~clr3;
      if (sysref_event && serial_link_enable && (phase_armed || !link_en_d)) begin
         next_multiframe_phase_set_flag = 1'b1;
         next_phase_armed = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state              <= LSCEN_BUS_IDLE;
         avs_readdata           <= 32'h0000_0000;
         avs_response           <= 2'b00;
         frame_end_comma_select <= LSCEN_RST_FRAME_END_CHAR_SELECT[1:0];
         one_channel_mode       <= LSCEN_RST_CHAN[LSCEN_CH_ONE];
         upper_pair_on          <= LSCEN_RST_CHAN[LSCEN_CH_UPPER];
         lower_pair_on          <= LSCEN_RST_CHAN[LSCEN_CH_LOWER];
         serial_link_enable     <= LSCEN_RST_CTRL[LSCEN_CT_LINK_EN];
         cal_enable             <= LSCEN_RST_CTRL[LSCEN_CT_CAL_EN];
         enc_8b10b              <= LSCEN_RST_CTRL[LSCEN_CT_ENC8B];
         realign_flag           <= LSCEN_RST_STATUS[LSCEN_ST_REALIGN];
         multiframe_phase_set_flag <= LSCEN_RST_STATUS[LSCEN_ST_PHASE];
         phase_armed            <= 1'b0;
         link_en_d              <= 1'b0;
      end else begin
         bus_state              <= next_bus_state;
         avs_readdata           <= next_readdata;
         avs_response           <= next_response;
         frame_end_comma_select <= next_frame_end_comma_select;
         one_channel_mode       <= next_one_channel_mode;
         upper_pair_on          <= next_upper_pair_on;
         lower_pair_on          <= next_lower_pair_on;
         serial_link_enable     <= next_serial_link_enable;
         cal_enable             <= next_cal_enable;
         enc_8b10b              <= next_enc_8b10b;
         realign_flag           <= next_realign_flag;
         multiframe_phase_set_flag <= next_multiframe_phase_set_flag;
         phase_armed            <= next_phase_armed;
         link_en_d              <= next_link_en_d;
      end
   end

   assign avs_waitrequest = (bus_state == LSCEN_BUS_IDLE);

   // comma character and insertion gate
   always_comb begin
      case (lscen_comma_e'(frame_end_comma_select))
         LSCEN_COMMA_K287: frame_end_comma_char = LSCEN_K287;
         LSCEN_COMMA_K281: frame_end_comma_char = LSCEN_K281;
         LSCEN_COMMA_K285: frame_end_comma_char = LSCEN_K285;
         default:          frame_end_comma_char = LSCEN_K287;
      endcase
      frame_end_comma_insert = serial_link_enable & enc_8b10b;
   end

   // frame layout from channel enables
   always_comb begin
      logic half;
      half = ~(upper_pair_on & lower_pair_on);
      frame_cfg = '0;
      frame_cfg.chan_on = one_channel_mode ? 4'b0001 :
                          {upper_pair_on, upper_pair_on, lower_pair_on, lower_pair_on};
      frame_cfg.lanes      = half ? HALF_L : FULL_L;
      frame_cfg.converters = half ? HALF_M : FULL_M;
      frame_cfg.tail_pad   = half & FULL_L[0];
      frame_cfg.swap_upper_to_lower = ~lower_pair_on & upper_pair_on;
   end

   // assertions
   wait_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not one cycle after request");
   comma_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_end_comma_insert |-> enc_8b10b)
      else $error("comma inserted outside 8b10b mode");
   comma_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_end_comma_select == 2'h2 |-> frame_end_comma_char == LSCEN_K285)
      else $error("comma code 2 not K28.5");
   realign_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sysref_realign |=> realign_flag)
      else $error("realign flag not set");
   phase_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      multiframe_phase_set_flag && !(wr_go && avs_address == LSCEN_ADDR_STATUS)
      |=> multiframe_phase_set_flag)
      else $error("phase flag dropped without clear");
   link_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_go && avs_address == LSCEN_ADDR_STATUS
      |=> avs_readdata[LSCEN_ST_LINK] == $past(live_sync.link_up))
      else $error("link status bit wrong");
   sync_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_go && avs_address == LSCEN_ADDR_STATUS
      |=> avs_readdata[LSCEN_ST_SYNC] == $past(live_sync.sync_n))
      else $error("sync status bit wrong");
   pll_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_go && avs_address == LSCEN_ADDR_STATUS
      |=> avs_readdata[LSCEN_ST_SPLL] == $past(live_sync.spll_lock) &&
          avs_readdata[LSCEN_ST_CPLL] == $past(live_sync.cpll_lock))
      else $error("pll lock bits wrong");
   single_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      one_channel_mode |-> frame_cfg.chan_on == 4'b0001)
      else $error("single channel mode leaves other channels on");
   half_lanes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !upper_pair_on && lower_pair_on |-> frame_cfg.lanes == HALF_L
      && frame_cfg.chan_on[3:2] == 2'b00)
      else $error("upper pair off but lanes or channels wrong");
   lower_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !lower_pair_on && upper_pair_on |-> frame_cfg.swap_upper_to_lower
      && frame_cfg.chan_on[1:0] == 2'b00)
      else $error("lower pair off without swap");
   tail_pad_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_cfg.tail_pad |-> FULL_L[0] && !(upper_pair_on && lower_pair_on))
      else $error("tail pad without odd half mode");
   zero_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      realign_flag && wr_go && avs_address == LSCEN_ADDR_STATUS
      && !avs_writedata[LSCEN_ST_REALIGN] |=> realign_flag)
      else $error("write of zero cleared sticky flag");
   realign_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      realign_flag && wr_go && avs_address == LSCEN_ADDR_STATUS
      && avs_writedata[LSCEN_ST_REALIGN] && !sysref_realign |=> !realign_flag)
      else $error("write of one did not clear realign flag");
   phase_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sysref_event && serial_link_enable && phase_armed |=> multiframe_phase_set_flag)
      else $error("phase flag not set by armed sysref");
   phase_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      multiframe_phase_set_flag && wr_go && avs_address == LSCEN_ADDR_STATUS
      && avs_writedata[LSCEN_ST_PHASE] && !sysref_event |=> !multiframe_phase_set_flag)
      else $error("write of one did not clear phase flag");
   half_conv_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(upper_pair_on && lower_pair_on) |-> frame_cfg.converters == HALF_M)
      else $error("converter count not halved");
   upper_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      upper_pair_on && !one_channel_mode |-> frame_cfg.chan_on[3:2] == 2'b11)
      else $error("upper pair enabled but channels off");
endmodule

// file: verification/lscen_rx_model.sv
// receiver model that answers link bring-up with sync and link status
`timescale 1ns/1ps
module lscen_rx_model #(
   parameter int SYNC_DELAY = 6
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // transmitter side
   input  wire logic serial_link_enable,
   // link status back to the device
   output logic      link_up,
   output logic      sync_n
);
   int cnt;
   // sync held asserted until code groups have been seen for a while
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         sync_n <= 1'b0;
         link_up <= 1'b0;
      end else if (!serial_link_enable) begin
         cnt <= 0;
         sync_n <= 1'b0;
         link_up <= 1'b0;
      end else begin
         if (cnt < SYNC_DELAY) cnt <= cnt + 1;
         sync_n <= (cnt >= SYNC_DELAY);
         link_up <= sync_n;
      end
   end
endmodule

// file: verification/link_status_channel_enable_tb.sv
// self-checking bench for the link status and channel enable registers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module link_status_channel_enable_tb;
   import lscen_pkg::*;
   localparam int FL = 5;
   localparam int FC = 4;
   logic               sys_clk, rst_n, avs_read, avs_write, spll, cpll, rx_link, rx_sync;
   logic [LSCEN_AW-1:0] avs_address;
   logic [31:0]        avs_writedata, avs_readdata, rs, r;
   logic [3:0]         avs_byteenable;
   logic               avs_waitrequest, sysref_realign, sysref_event;
   logic [1:0]         avs_response;
   logic               serial_link_enable, cal_enable, enc_8b10b, frame_end_comma_insert;
   logic [7:0]         frame_end_comma_char, st;
   lscen_frame_s       frame_cfg;
   lscen_live_s        live;
   logic [33:0]        exp_q[$];
   logic [33:0]        e;
   logic [7:0]         kc [4] = '{LSCEN_K287, LSCEN_K281, LSCEN_K285, LSCEN_K287};
   logic [2:0]         cl [4] = '{3'h2, 3'h1, 3'h7, 3'h3};
   logic [2:0]         ctl [4] = '{3'h4, 3'h5, 3'h1, 3'h2};
   int                 mismatches, cmp_count, cyc;

   assign live = {rx_link, rx_sync, spll, cpll};

   lscen_regs #(.FULL_LANES(FL), .FULL_CONV(FC)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .live_in(live), .sysref_realign(sysref_realign),
      .sysref_event(sysref_event), .serial_link_enable(serial_link_enable),
      .cal_enable(cal_enable), .enc_8b10b(enc_8b10b),
      .frame_end_comma_insert(frame_end_comma_insert),
      .frame_end_comma_char(frame_end_comma_char), .frame_cfg(frame_cfg));

   lscen_rx_model #(.SYNC_DELAY(6)) rx (
      .sys_clk(sys_clk), .rst_n(rst_n), .serial_link_enable(serial_link_enable),
      .link_up(rx_link), .sync_n(rx_sync));

   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   function automatic lscen_frame_s exp_frame(input logic [2:0] c);
      lscen_frame_s f;
      logic         half;
      half = c[1] ^ c[0];
      f.lanes = half ? 4'((FL + 1) / 2) : 4'(FL);
      f.converters = half ? 4'(FC / 2) : 4'(FC);
      f.tail_pad = half & (FL % 2 == 1);
      f.swap_upper_to_lower = c[1] & !c[0];
      f.chan_on = {c[1], c[1], c[0], c[0]};
      return f;
   endfunction

   task automatic close_out();
      $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d,
                      input logic [3:0] be, input logic [33:0] x);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      if (!wr) exp_q.push_back(x);
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic pulse(input logic realign);
      @(posedge sys_clk);
      if (realign) sysref_realign <= 1'b1;
      else sysref_event <= 1'b1;
      @(posedge sys_clk);
      sysref_realign <= 1'b0;
      sysref_event <= 1'b0;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         $display("MISMATCH t=%0t timeout", $time);
         close_out();
      end
      if (avs_read && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("MISMATCH t=%0t read with no expectation", $time);
         end else begin
            e = exp_q.pop_front();
            `CHK({avs_response, avs_readdata}, e)
         end
      end
   end

   initial begin
      rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0;
      avs_writedata = '0; avs_byteenable = '0; spll = 1'b0; cpll = 1'b0;
      sysref_realign = 1'b0; sysref_event = 1'b0; rs = 32'd62892;
      mismatches = 0; cmp_count = 0; cyc = 0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(1'b0, LSCEN_ADDR_STATUS, 8'h0, 4'hf, 34'h0);
      bus(1'b0, LSCEN_ADDR_CHAN, 8'h0, 4'hf, 34'h3);
      bus(1'b0, LSCEN_ADDR_FRAME_END_CHAR_SELECT, 8'h0, 4'hf, 34'h0);
      `CHK(frame_end_comma_char, LSCEN_K287)
      `CHK(frame_cfg, exp_frame(3'h3))
      $display("test reset done");
      for (int i = 3; i >= 0; i--) begin
         bus(1'b1, LSCEN_ADDR_FRAME_END_CHAR_SELECT, 8'(i), 4'h1, 34'h0);
         bus(1'b0, LSCEN_ADDR_FRAME_END_CHAR_SELECT, 8'h0, 4'hf, 34'(i));
         `CHK(frame_end_comma_char, kc[i])
      end
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, LSCEN_ADDR_CTRL, {5'h0, ctl[i]}, 4'h1, 34'h0);
         `CHK({enc_8b10b, cal_enable, serial_link_enable}, ctl[i])
         `CHK(frame_end_comma_insert, ctl[i][0] & ctl[i][2])
      end
      bus(1'b1, LSCEN_ADDR_CTRL, 8'h0, 4'h1, 34'h0);
      $display("test comma done");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, LSCEN_ADDR_CHAN, {5'h0, cl[i]}, 4'h1, 34'h0);
         bus(1'b0, LSCEN_ADDR_CHAN, 8'h0, 4'hf, 34'(cl[i]));
         if (cl[i][2]) `CHK(frame_cfg.chan_on, 4'h1)
         else `CHK(frame_cfg, exp_frame(cl[i]))
      end
      bus(1'b1, LSCEN_ADDR_CHAN, 8'h1, 4'h0, 34'h0);
      bus(1'b0, LSCEN_ADDR_CHAN, 8'h0, 4'hf, 34'h3);
      $display("test channels done");
      r = xs();
      spll <= r[0];
      cpll <= r[1];
      pulse(1'b0);
      repeat (4) @(posedge sys_clk);
      st = {5'h0, r[0], 1'b0, r[1]};
      bus(1'b0, LSCEN_ADDR_STATUS, 8'h0, 4'hf, 34'(st));
      bus(1'b1, LSCEN_ADDR_CTRL, 8'h1, 4'h1, 34'h0);
      for (int n = 0; n < 50 && rx_link !== 1'b1; n++) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      pulse(1'b0);
      pulse(1'b1);
      st = st | 8'h78;
      bus(1'b0, LSCEN_ADDR_STATUS, 8'h0, 4'hf, 34'(st));
      bus(1'b1, LSCEN_ADDR_STATUS, 8'(xs()) & 8'he7, 4'h1, 34'h0);
      bus(1'b0, LSCEN_ADDR_STATUS, 8'h0, 4'hf, 34'(st));
      bus(1'b1, LSCEN_ADDR_STATUS, 8'h10, 4'h1, 34'h0);
      bus(1'b0, LSCEN_ADDR_STATUS, 8'h0, 4'hf, 34'(st & 8'hef));
      bus(1'b1, LSCEN_ADDR_STATUS, 8'h08, 4'h1, 34'h0);
      bus(1'b0, LSCEN_ADDR_STATUS, 8'h0, 4'hf, 34'(st & 8'he7));
      $display("test status done");
      bus(1'b1, 14'h0, 8'h55, 4'h1, 34'h0);
      bus(1'b0, 14'h0, 8'h0, 4'hf, {2'b11, 32'h0});
      bus(1'b0, LSCEN_ADDR_CHAN, 8'h0, 4'hf, 34'h3);
      $display("test unmapped done");
      close_out();
   end
endmodule
